/* hw/oear_pkg.sv */
// Shared constants and types for the OTG event and accessory register block
package oear_pkg;

   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned EVT_W = 5;

   // Register addresses, immediate access space
   localparam logic [ADDR_W-1:0] ADDR_EVT_LATCH = 6'h14;
   localparam logic [ADDR_W-1:0] ADDR_LINE_VIEW = 6'h15;
   localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 6'h16;
   localparam logic [ADDR_W-1:0] ADDR_ACC_CTRL = 6'h19;
   localparam logic [ADDR_W-1:0] ADDR_ACC_IRQ_EN = 6'h1d;
   localparam logic [ADDR_W-1:0] ADDR_ACC_STATUS = 6'h20;
   localparam logic [ADDR_W-1:0] ADDR_VEND_CONV = 6'h36;

   // Offsets within a write/set/clear window
   localparam logic [1:0] SEL_WRITE = 2'h0;
   localparam logic [1:0] SEL_SET = 2'h1;
   localparam logic [1:0] SEL_CLEAR = 2'h2;

   // Event latch bit positions
   localparam int unsigned EVT_UNPLUG = 0;
   localparam int unsigned EVT_BUS_PWR = 1;
   localparam int unsigned EVT_SESS_OK = 2;
   localparam int unsigned EVT_SESS_OVER = 3;
   localparam int unsigned EVT_ID_GND = 4;

   // Accessory control fields
   localparam int unsigned ACC_ID_LOW = 1;
   localparam int unsigned ACC_TX_ROUTE = 2;
   localparam int unsigned ACC_RX_ROUTE = 3;
   localparam int unsigned ACC_LEFT = 4;
   localparam int unsigned ACC_RIGHT = 5;
   localparam int unsigned ACC_MIC = 6;
   localparam logic [DATA_W-1:0] ACC_WMASK = 8'h7e;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

   // Accessory interrupt enable fields
   localparam int unsigned IEN_OPEN_RISE = 0;
   localparam int unsigned IEN_OPEN_FALL = 1;
   localparam int unsigned IEN_CONV = 5;
   localparam logic [DATA_W-1:0] IEN_WMASK = 8'h23;
   localparam logic [DATA_W-1:0] IEN_RESET = 8'h00;

   // Accessory status fields
   localparam int unsigned STAT_OPEN = 0;
   localparam int unsigned STAT_CODE_LO = 3;
   localparam int unsigned STAT_DONE = 6;

   // Vendor conversion register fields
   localparam int unsigned VC_DONE = 3;
   localparam int unsigned VC_START = 4;
   localparam logic [DATA_W-1:0] VC_WMASK = 8'h30;
   localparam logic [DATA_W-1:0] VC_RESET = 8'h00;

   localparam logic [DATA_W-1:0] SCRATCH_RESET = 8'h00;
   localparam logic [2:0] CODE_RESET = 3'h0;

   // Resistor conversion time
   localparam int unsigned CONV_TIME_US = 282;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned CONV_CYCLES_DEF = CONV_TIME_US * CLK_MHZ;

   typedef enum logic [0:0] {
      CT_IDLE = 1'b0,
      CT_BUSY = 1'b1
   } oear_conv_state_t;

endpackage : oear_pkg

/* hw/oear_edge_latch.sv */
// Edge detector with per-bit masks and sticky latch, clear loses to set
`timescale 1ns/1ps
module oear_edge_latch #(
   parameter int unsigned W = 5
) (
   input wire logic core_clk_i,         // System clock
   input wire logic rst_i,              // Synchronous reset
   input wire logic [W-1:0] level_i,    // Watched levels
   input wire logic [W-1:0] rise_en_i,  // Rising edge enables
   input wire logic [W-1:0] fall_en_i,  // Falling edge enables
   input wire logic clr_i,              // Clear latch
   output logic [W-1:0] evt_o,          // Enabled edge this cycle
   output logic [W-1:0] latch_o         // Sticky events
);
   logic [W-1:0] prev_reg;
   logic [W-1:0] latch_reg;
   logic [W-1:0] latch_next;
   logic armed_reg;
   wire [W-1:0] rise_w = level_i & ~prev_reg;
   wire [W-1:0] fall_w = ~level_i & prev_reg;

   // No edges until prev holds a real sample, avoids a false event at release
   assign evt_o = armed_reg ? ((rise_w & rise_en_i) | (fall_w & fall_en_i)) : '0;
   assign latch_next = (clr_i ? '0 : latch_reg) | evt_o;
   assign latch_o = latch_reg;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         prev_reg <= '0;
         latch_reg <= '0;
         armed_reg <= 1'b0;
      end else begin
         prev_reg <= level_i;
         latch_reg <= latch_next;
         armed_reg <= 1'b1;
      end
   end
endmodule : oear_edge_latch

/* hw/oear_conv_timer.sv */
// Resistor conversion duration timer
`timescale 1ns/1ps
module oear_conv_timer
   import oear_pkg::*;
#(
   parameter int unsigned CYCLES = oear_pkg::CONV_CYCLES_DEF
) (
   input wire logic core_clk_i,  // System clock
   input wire logic rst_i,       // Synchronous reset
   input wire logic start_i,     // Begin conversion, ignored when busy
   output logic busy_o,          // Conversion running
   output logic done_o           // Last cycle of conversion
);
   localparam int unsigned CNT_W = $clog2(CYCLES) + 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
   oear_conv_state_t state_reg;
   oear_conv_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   assign busy_o = (state_reg == CT_BUSY);
   assign done_o = busy_o && (cnt_reg == LAST);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         CT_IDLE: begin
            cnt_next = '0;
            if (start_i) begin
               state_next = CT_BUSY;
            end
         end
         CT_BUSY: begin
            cnt_next = cnt_reg + 1'b1;
            if (done_o) begin
               state_next = CT_IDLE;
               cnt_next = '0;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= CT_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule : oear_conv_timer

/* hw/oear_regs.sv */
// OTG event latch, line view, scratch and accessory register block
`timescale 1ns/1ps
module oear_regs #(
   parameter int unsigned CONV_CYCLES = oear_pkg::CONV_CYCLES_DEF
) (
   input wire logic core_clk_i,                           // 40 MHz clock
   input wire logic rst_i,                                // Sync reset, high
   input wire logic [oear_pkg::ADDR_W-1:0] reg_addr_i,    // Register address
   input wire logic [oear_pkg::DATA_W-1:0] reg_wdata_i,   // Write data
   input wire logic reg_wr_i,                             // Write strobe
   input wire logic reg_rd_i,                             // Read strobe
   output logic [oear_pkg::DATA_W-1:0] reg_rdata_o,       // Read data
   output logic reg_rvalid_o,                             // Read data valid
   input wire logic host_mode_i,                          // Host mode active
   input wire logic [oear_pkg::EVT_W-1:0] evt_rise_en_i,  // Rising masks
   input wire logic [oear_pkg::EVT_W-1:0] evt_fall_en_i,  // Falling masks
   input wire logic host_unplug_i,                        // Disconnect level
   input wire logic bus_power_ok_i,                       // Bus power valid
   input wire logic session_ok_i,                         // Session valid
   input wire logic session_over_i,                       // Session end
   input wire logic id_grounded_i,                        // ID grounded
   input wire logic [1:0] line_state_i,                   // Live line state
   input wire logic accessory_mode_select_i,              // Accessory mode
   input wire logic ulpi_data0_i,                         // UART transmit in
   input wire logic dp_i,                                 // DP line level
   input wire logic dm_i,                                 // DM line level
   input wire logic id_open_state_i,                      // ID floating
   input wire logic [2:0] id_resistance_code_i,           // Converter result
   input wire logic vendor_conv_irq_en_i,                 // Vendor enable
   output logic alt_int_o,                                // Alt interrupt
   output logic ulpi_data1_o,                             // Data line 1 out
   output logic ulpi_data1_oe_n_o,                        // Data line 1 oe, low
   output logic dm_o,                                     // DM out
   output logic dm_oe_n_o,                                // DM oe, low
   output logic left_speaker_pin_o,                       // Left speaker out
   output logic left_speaker_oe_n_o,                      // Left switch, low
   output logic right_speaker_pin_o,                      // Right speaker out
   output logic right_speaker_oe_n_o,                     // Right switch, low
   output logic id_pin_o,                                 // ID pin out
   output logic id_pin_oe_n_o,                            // ID pulldown, low
   output logic se_rx_disable_o                           // SE receivers off
);
   import oear_pkg::*;

   function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
      return (addr >= base) && (addr <= base + 6'h02);
   endfunction : in_window

   function automatic logic [DATA_W-1:0] apply_wsc(input logic [DATA_W-1:0] cur,
                                                   input logic [DATA_W-1:0] wd,
                                                   input logic [ADDR_W-1:0] addr,
                                                   input logic [ADDR_W-1:0] base,
                                                   input logic [DATA_W-1:0] mask);
      logic [ADDR_W-1:0] diff;
      logic [DATA_W-1:0] nv;
      diff = addr - base;
      unique case (diff[1:0])
         SEL_WRITE: nv = wd;
         SEL_SET: nv = cur | wd;
         SEL_CLEAR: nv = cur & ~wd;
         default: nv = cur;
      endcase
      return (nv & mask) | (cur & ~mask);
   endfunction : apply_wsc

   logic [DATA_W-1:0] scratch_reg;
   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] ien_reg;
   logic [DATA_W-1:0] vc_reg;
   logic [2:0] code_reg;
   logic done_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [EVT_W-1:0] evt_pulse;
   logic [EVT_W-1:0] evt_latch;
   logic [0:0] open_evt;
   logic conv_busy;
   logic conv_done;

   // Access decode
   wire hit_evt = (reg_addr_i == ADDR_EVT_LATCH);
   wire hit_view = (reg_addr_i == ADDR_LINE_VIEW);
   wire hit_scr = in_window(reg_addr_i, ADDR_SCRATCH);
   wire hit_acc = in_window(reg_addr_i, ADDR_ACC_CTRL);
   wire hit_ien = in_window(reg_addr_i, ADDR_ACC_IRQ_EN);
   wire hit_stat = (reg_addr_i == ADDR_ACC_STATUS);
   wire hit_vc = in_window(reg_addr_i, ADDR_VEND_CONV);
   wire evt_read = reg_rd_i && hit_evt;
   wire vc_read = reg_rd_i && hit_vc;

   // Comparator events; unplug mask gated outside host mode
   wire [EVT_W-1:0] levels_w = {id_grounded_i, session_over_i, session_ok_i,
                                bus_power_ok_i, host_unplug_i};
   wire [EVT_W-1:0] host_gate_w = {{(EVT_W-1){1'b1}}, host_mode_i};

   oear_edge_latch #(
      .W(EVT_W)
   ) u_evt (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i(levels_w),
      .rise_en_i(evt_rise_en_i & host_gate_w),
      .fall_en_i(evt_fall_en_i & host_gate_w),
      .clr_i(evt_read),
      .evt_o(evt_pulse),
      .latch_o(evt_latch)
   );

   oear_edge_latch #(
      .W(1)
   ) u_open (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i(id_open_state_i),
      .rise_en_i(ien_reg[IEN_OPEN_RISE]),
      .fall_en_i(ien_reg[IEN_OPEN_FALL]),
      .clr_i(1'b0),
      .evt_o(open_evt),
      .latch_o()
   );

   // Start only from a write or set that leaves the start bit high
   wire [DATA_W-1:0] vc_wr_w = apply_wsc(vc_reg, reg_wdata_i, reg_addr_i, ADDR_VEND_CONV,
                                         VC_WMASK);
   wire conv_start = reg_wr_i && hit_vc && vc_wr_w[VC_START] && !conv_busy;

   oear_conv_timer #(
      .CYCLES(CONV_CYCLES)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(conv_start),
      .busy_o(conv_busy),
      .done_o(conv_done)
   );

   // Next register values
   wire [DATA_W-1:0] scratch_next = (reg_wr_i && hit_scr) ?
      apply_wsc(scratch_reg, reg_wdata_i, reg_addr_i, ADDR_SCRATCH, 8'hff) : scratch_reg;
   wire [DATA_W-1:0] acc_next = (reg_wr_i && hit_acc) ?
      apply_wsc(acc_reg, reg_wdata_i, reg_addr_i, ADDR_ACC_CTRL, ACC_WMASK) : acc_reg;
   wire [DATA_W-1:0] ien_next = (reg_wr_i && hit_ien) ?
      apply_wsc(ien_reg, reg_wdata_i, reg_addr_i, ADDR_ACC_IRQ_EN, IEN_WMASK) : ien_reg;
   wire [DATA_W-1:0] vc_held = (reg_wr_i && hit_vc) ? vc_wr_w : vc_reg;
   wire [DATA_W-1:0] vc_next = conv_done ? (vc_held & ~(8'h01 << VC_START)) : vc_held;
   // Completion wins over a same-cycle clearing read
   wire done_next = conv_done || (done_reg && !vc_read);

   // Alternate interrupt sources
   wire conv_irq = conv_done && !done_reg &&
                   (ien_reg[IEN_CONV] || vendor_conv_irq_en_i);
   wire alt_next = conv_irq || open_evt[0];

   // Read views
   wire [DATA_W-1:0] evt_view = {{(DATA_W-EVT_W){1'b0}}, evt_latch};
   wire [DATA_W-1:0] line_view = {6'h00, line_state_i};
   wire [DATA_W-1:0] stat_view = {1'b0, done_reg, code_reg, 2'b00, id_open_state_i};
   wire [DATA_W-1:0] vc_view = {vc_reg[7:4], done_reg, code_reg};
   assign rdata_next = hit_evt ? evt_view :
                       hit_view ? line_view :
                       hit_scr ? scratch_reg :
                       hit_acc ? acc_reg :
                       hit_ien ? ien_reg :
                       hit_stat ? stat_view :
                       hit_vc ? vc_view : 8'h00;

   // Pin behaviour; the transmit route and the data line 1 enable need accessory mode, speaker switches do not
   wire tx_on = accessory_mode_select_i && acc_reg[ACC_TX_ROUTE];
   wire dm_level = tx_on ? ulpi_data0_i : dm_i;
   wire right_closed = acc_reg[ACC_RIGHT] || acc_reg[ACC_MIC];
   wire audio_on = acc_reg[ACC_LEFT] || right_closed;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         scratch_reg <= SCRATCH_RESET;
         acc_reg <= ACC_RESET;
         ien_reg <= IEN_RESET;
         vc_reg <= VC_RESET;
         code_reg <= CODE_RESET;
         done_reg <= 1'b0;
      end else begin
         scratch_reg <= scratch_next;
         acc_reg <= acc_next;
         ien_reg <= ien_next;
         vc_reg <= vc_next;
         done_reg <= done_next;
         if (conv_done) begin
            code_reg <= id_resistance_code_i;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
         alt_int_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_next : 8'h00;
         reg_rvalid_o <= reg_rd_i;
         alt_int_o <= alt_next;
      end
   end

   // Analog switches are modelled as driven copies of the connected line
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ulpi_data1_o <= 1'b1;
         ulpi_data1_oe_n_o <= 1'b1;
         dm_o <= 1'b0;
         dm_oe_n_o <= 1'b1;
         left_speaker_pin_o <= 1'b0;
         left_speaker_oe_n_o <= 1'b1;
         right_speaker_pin_o <= 1'b0;
         right_speaker_oe_n_o <= 1'b1;
         id_pin_o <= 1'b0;
         id_pin_oe_n_o <= 1'b1;
         se_rx_disable_o <= 1'b0;
      end else begin
         ulpi_data1_o <= acc_reg[ACC_RX_ROUTE] ? dp_i : 1'b1;
         ulpi_data1_oe_n_o <= !accessory_mode_select_i;
         dm_o <= ulpi_data0_i;
         dm_oe_n_o <= !tx_on;
         left_speaker_pin_o <= dm_level;
         left_speaker_oe_n_o <= !acc_reg[ACC_LEFT];
         right_speaker_pin_o <= dp_i;
         right_speaker_oe_n_o <= !right_closed;
         id_pin_o <= 1'b0;
         id_pin_oe_n_o <= !acc_reg[ACC_ID_LOW];
         se_rx_disable_o <= audio_on;
      end
   end

   // Event latch, line view and scratch checks; edge checks skip the blind cycle after reset
   a_latch_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(session_ok_i) && evt_rise_en_i[EVT_SESS_OK] && !$past(rst_i)
      |=> evt_latch[EVT_SESS_OK])
      else $error("session rise not latched");

   a_read_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
      evt_read && evt_pulse == '0 |=> evt_latch == '0 && reg_rdata_o[7:5] == 3'b000)
      else $error("event latch not cleared by read");

   a_read_keeps_new: assert property (@(posedge core_clk_i) disable iff (rst_i)
      evt_read && evt_pulse[EVT_ID_GND] |=> evt_latch[EVT_ID_GND])
      else $error("event lost during read");

   a_unplug_host: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !host_mode_i && !evt_latch[EVT_UNPLUG] |=> !evt_latch[EVT_UNPLUG])
      else $error("unplug latched outside host mode");

   a_line_view: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && hit_view |=> reg_rvalid_o && reg_rdata_o == {6'h00, $past(line_state_i)})
      else $error("line view mismatch");

   a_scratch_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == ADDR_SCRATCH + 6'h01
      |=> scratch_reg == ($past(scratch_reg) | $past(reg_wdata_i)))
      else $error("scratch set wrong");

   // Pin and control register checks, each one cycle behind its cause
   a_data1_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !acc_reg[ACC_RX_ROUTE] && accessory_mode_select_i |=> ulpi_data1_o && !ulpi_data1_oe_n_o)
      else $error("data line 1 not held high");

   a_rx_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
      acc_reg[ACC_RX_ROUTE] |=> ulpi_data1_o == $past(dp_i))
      else $error("receive route does not follow DP");

   a_tx_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
      tx_on |=> !dm_oe_n_o && dm_o == $past(ulpi_data0_i))
      else $error("transmit route does not drive DM");

   a_id_ground: assert property (@(posedge core_clk_i) disable iff (rst_i)
      acc_reg[ACC_ID_LOW] |=> !id_pin_oe_n_o && !id_pin_o)
      else $error("ID pin not grounded");

   a_acc_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && hit_acc |=> acc_reg[0] == 1'b0 && acc_reg[7] == 1'b0)
      else $error("read-only control bit stored");

   a_left_switch: assert property (@(posedge core_clk_i) disable iff (rst_i)
      acc_reg[ACC_LEFT] |=> !left_speaker_oe_n_o && left_speaker_pin_o == $past(dm_level))
      else $error("left switch open or wrong level");

   a_right_switch: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (acc_reg[ACC_RIGHT] || acc_reg[ACC_MIC]) |=> !right_speaker_oe_n_o && se_rx_disable_o)
      else $error("right switch open or receivers on");

   a_right_open: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !acc_reg[ACC_RIGHT] && !acc_reg[ACC_MIC] |=> right_speaker_oe_n_o)
      else $error("right switch closed with both bits clear");

   // Interrupt and status checks
   a_ien_unused: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && hit_ien |=> ien_reg[4:2] == 3'b000 && ien_reg[7:6] == 2'b00)
      else $error("unimplemented enable bit stored");

   a_open_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(id_open_state_i) && ien_reg[IEN_OPEN_RISE] && !$past(rst_i) |=> alt_int_o)
      else $error("ID float rise not signalled");

   a_stat_view: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && hit_stat |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[2:1] == 2'b00
      && reg_rdata_o[0] == $past(id_open_state_i))
      else $error("status view reserved or float bit wrong");

   a_stat_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && hit_stat |=> reg_rdata_o[5:3] == $past(code_reg)
      && reg_rdata_o[6] == $past(done_reg))
      else $error("status code or done bit wrong");

   a_conv_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
      conv_done && !done_reg && ien_reg[IEN_CONV] |=> alt_int_o && done_reg && !vc_reg[VC_START])
      else $error("conversion completion not signalled");

   a_stat_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
      done_reg && !vc_read |=> done_reg)
      else $error("conversion done cleared without vendor read");
endmodule : oear_regs

/* verification/oear_link_model.sv */
// Link-side model issuing immediate register accesses
`timescale 1ns/1ps
module oear_link_model (
   input wire logic core_clk_i,                        // Clock
   input wire logic [oear_pkg::DATA_W-1:0] reg_rdata_i, // Read data
   input wire logic reg_rvalid_i,                      // Read valid
   output logic [oear_pkg::ADDR_W-1:0] reg_addr_o,     // Address
   output logic [oear_pkg::DATA_W-1:0] reg_wdata_o,    // Write data
   output logic reg_wr_o,                              // Write strobe
   output logic reg_rd_o                               // Read strobe
);
   import oear_pkg::*;
   initial begin
      reg_addr_o = '0;
      reg_wdata_o = '0;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // Released bus shows inverted pattern; a read inverts the address only and leaves write data as it was
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rvalid_i ? reg_rdata_i : 'x;
   endtask : rd_reg
endmodule : oear_link_model

/* verification/tb_otg_event_and_accessory_regs.sv */
// Self-checking bench for the OTG event and accessory registers
`timescale 1ns/1ps
module tb_otg_event_and_accessory_regs;
   import oear_pkg::*;
   localparam logic [ADDR_W-1:0] BASES[3] = '{ADDR_SCRATCH, ADDR_ACC_CTRL, ADDR_ACC_IRQ_EN};
   localparam logic [DATA_W-1:0] MASKS[3] = '{8'hff, ACC_WMASK, IEN_WMASK};
   localparam int unsigned CONV_N = 8;
   logic core_clk_i, rst_i, wr, rd, rvalid, host, mode, d0, dp, dm, idop, vend;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, rd_v, d, m;
   logic [4:0] rise_en, fall_en, lv;
   logic [1:0] line, sel;
   logic [2:0] code;
   logic alt, d1, dm_o, dm_oe_n, spl_oe_n, spr_oe_n, idp_oe_n, serx;
   logic d1_oe_n, spl, spr, idp;
   int fails, num_checks, n;
   int mdl[3];
   oear_regs #(.CONV_CYCLES(CONV_N)) i_oear_regs (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .host_mode_i(host),
      .evt_rise_en_i(rise_en), .evt_fall_en_i(fall_en), .host_unplug_i(lv[0]),
      .bus_power_ok_i(lv[1]), .session_ok_i(lv[2]), .session_over_i(lv[3]),
      .id_grounded_i(lv[4]), .line_state_i(line), .accessory_mode_select_i(mode),
      .ulpi_data0_i(d0), .dp_i(dp), .dm_i(dm), .id_open_state_i(idop),
      .id_resistance_code_i(code), .vendor_conv_irq_en_i(vend), .alt_int_o(alt),
      .ulpi_data1_o(d1), .ulpi_data1_oe_n_o(d1_oe_n), .dm_o(dm_o), .dm_oe_n_o(dm_oe_n),
      .left_speaker_pin_o(spl), .left_speaker_oe_n_o(spl_oe_n), .right_speaker_pin_o(spr),
      .right_speaker_oe_n_o(spr_oe_n), .id_pin_o(idp), .id_pin_oe_n_o(idp_oe_n),
      .se_rx_disable_o(serx));
   oear_link_model i_oear_link_model (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
      .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
      .reg_rd_o(rd));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task automatic r(input logic [ADDR_W-1:0] a);
      i_oear_link_model.rd_reg(a, rd_v);
   endtask : r
   task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      i_oear_link_model.wr_reg(a, v);
   endtask : w
   task automatic wait_alt(input int lim);
      n = 0;
      while (alt !== 1'b1 && n < lim) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
   endtask : wait_alt
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h20c7bce6));
      {rst_i, host, mode, d0, dp, dm, idop, vend} = 8'h80;
      {rise_en, fall_en, lv, line, code} = '0;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      // Windowed registers, first read checks reset value
      for (int j = 0; j < 3; j++) begin
         for (int k = 0; k < 10; k++) begin
            r(BASES[j] + 6'($urandom_range(2)));
            chk(rd_v, 8'(mdl[j]));
            sel = 2'($urandom_range(2));
            d = 8'($urandom);
            if (j == 1) d &= 8'hf3;
            w(BASES[j] + 6'(sel), d);
            if (sel == 0) mdl[j] = d & MASKS[j];
            else if (sel == 1) mdl[j] |= d & MASKS[j];
            else mdl[j] &= ~d;
            m = 8'(mdl[j]);
            if (j == 1) begin
               repeat (2) @(posedge core_clk_i);
               #1;
               chk({spl_oe_n, spr_oe_n, serx, idp_oe_n}, {~m[4], ~|m[6:5], |m[6:4], ~m[1]});
            end
         end
      end
      w(ADDR_ACC_CTRL, 8'h00);
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk_i);
         line <= 2'($urandom);
         r(ADDR_LINE_VIEW);
         chk(rd_v, {6'h00, line});
      end
      // Rising then falling edge on every comparator
      r(ADDR_EVT_LATCH);
      @(posedge core_clk_i);
      host <= 1'b1;
      rise_en <= 5'h1f;
      fall_en <= 5'h1f;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) begin
            @(posedge core_clk_i);
            lv[i] <= ~lv[i];
            repeat (3) @(posedge core_clk_i);
            r(ADDR_EVT_LATCH);
            chk(rd_v, 8'(1 << i));
         end
      end
      // Edge lands on the very edge that samples the clearing read
      fork
         r(ADDR_EVT_LATCH);
         begin
            @(posedge core_clk_i);
            lv[4] <= ~lv[4];
         end
      join
      chk(rd_v, 8'h00);
      r(ADDR_EVT_LATCH);
      chk(rd_v, 8'h10);
      @(posedge core_clk_i);
      host <= 1'b0;
      lv[0] <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      r(ADDR_EVT_LATCH);
      chk(rd_v, 8'h00);
      // Routes programmed before accessory mode
      for (int p = 0; p < 2; p++) begin
         w(ADDR_ACC_CTRL, p ? 8'h04 : 8'h08);
         @(posedge core_clk_i);
         mode <= 1'b1;
         for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            dp <= 1'($urandom);
            d0 <= 1'($urandom);
            dm <= 1'($urandom);
            repeat (2) @(posedge core_clk_i);
            #1;
            chk(8'(d1), p ? 8'h01 : 8'(dp));
            chk(8'({d1_oe_n, spl, spr, idp}), 8'({1'b0, p ? d0 : dm, dp, 1'b0}));
            if (p) chk(8'({dm_oe_n, dm_o}), 8'({1'b0, d0}));
         end
         @(posedge core_clk_i);
         mode <= 1'b0;
      end
      // Conversion via own enable, then via vendor enable
      for (int p = 0; p < 2; p++) begin
         w(ADDR_ACC_IRQ_EN, p ? 8'h00 : 8'h20);
         @(posedge core_clk_i);
         vend <= 1'(p);
         code <= p ? 3'h7 : 3'($urandom_range(5));
         w(ADDR_VEND_CONV, 8'h10);
         wait_alt(40);
         chk(8'(alt), 8'h01);
         chk(8'(n), 8'(CONV_N));
         r(ADDR_ACC_STATUS);
         chk(rd_v, {2'b01, code, 3'b000});
         r(ADDR_ACC_STATUS);
         chk(rd_v, {2'b01, code, 3'b000});
         r(ADDR_VEND_CONV);
         chk(rd_v, {4'h0, 1'b1, code});
         r(ADDR_ACC_STATUS);
         chk(rd_v, {2'b00, code, 3'b000});
      end
      // ID pull-up lives outside this block and is taken as enabled
      w(ADDR_ACC_IRQ_EN, 8'h03);
      for (int p = 0; p < 2; p++) begin
         @(posedge core_clk_i);
         idop <= ~idop;
         wait_alt(6);
         chk(8'(alt), 8'h01);
         r(ADDR_ACC_STATUS);
         chk(rd_v, {2'b00, code, 2'b00, idop});
      end
      give_verdict();
   end
endmodule : tb_otg_event_and_accessory_regs
